// [rtl/scfp_pkg.sv]
`default_nettype none

package scfp_pkg;

    // ********************************************************
    // control characters of the link
    // ********************************************************
    localparam logic [7:0] SCFP_STX = 8'h02;
    localparam logic [7:0] SCFP_ETX = 8'h03;
    localparam logic [7:0] SCFP_EOT = 8'h04;
    localparam logic [7:0] SCFP_ACK = 8'h06;
    localparam logic [7:0] SCFP_LF = 8'h0A;
    localparam logic [7:0] SCFP_CR = 8'h0D;
    localparam logic [7:0] SCFP_NAK = 8'h15;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int SCFP_CLK_PERIOD_NS = 25;
    localparam int SCFP_TICK_US = 1000;
    localparam int SCFP_TICK_CYCLES = (SCFP_TICK_US * 1000) / SCFP_CLK_PERIOD_NS;
    localparam int SCFP_RSP_TIMEOUT_S = 15;
    localparam int SCFP_RCV_TIMEOUT_S = 15;
    localparam int SCFP_RSP_TIMEOUT_TICKS = (SCFP_RSP_TIMEOUT_S * 1000 * 1000) / SCFP_TICK_US;
    localparam int SCFP_RCV_TIMEOUT_TICKS = (SCFP_RCV_TIMEOUT_S * 1000 * 1000) / SCFP_TICK_US;
    localparam int SCFP_PRE_W = 16;
    localparam int SCFP_TMR_W = 14;

    // ********************************************************
    // response buffer: one byte plus an end-of-block flag
    // ********************************************************
    localparam int SCFP_BYTE_W = 8;
    localparam int SCFP_FIFO_W = 9;
    localparam int SCFP_FIFO_DEPTH = 32;
    localparam int SCFP_LAST_BIT = 8;

    // ********************************************************
    // protocol states
    // ********************************************************
    typedef enum logic [3:0] {
        SCFP_ST_IDLE,
        SCFP_ST_RX_BODY,
        SCFP_ST_WAIT_VERDICT,
        SCFP_ST_REPLY,
        SCFP_ST_WAIT_EOT,
        SCFP_ST_WAIT_BLOCK,
        SCFP_ST_TX_STX,
        SCFP_ST_TX_DATA,
        SCFP_ST_TX_CR,
        SCFP_ST_TX_LF,
        SCFP_ST_TX_ETX,
        SCFP_ST_TX_DRAIN,
        SCFP_ST_WAIT_ACK,
        SCFP_ST_TX_EOT
    } scfp_state_t;

endpackage

`default_nettype wire

// [rtl/scfp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module scfp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [WIDTH-1:0] odata;
        logic ovalid;
    } scfp_fifo_regs_t;

    scfp_fifo_regs_t r;
    scfp_fifo_regs_t next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic load;

    // ********************************************************
    // handshakes
    // ********************************************************
    assign in_ready = r.cnt != (AW + 1)'(DEPTH);
    assign push = in_valid && in_ready;
    // head register refills whenever it is empty or being taken
    assign load = (r.cnt != '0) && (!r.ovalid || out_ready);
    assign out_data = r.odata;
    assign out_valid = r.ovalid;

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wp = r.wp + AW'(1);
        end
        if (load) begin
            next_r.rp = r.rp + AW'(1);
            next_r.odata = mem[r.rp];
            next_r.ovalid = 1'b1;
        end else if (out_ready) begin
            next_r.ovalid = 1'b0;
        end
        next_r.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[r.wp] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule // scfp_fifo

`default_nettype wire

// [rtl/scfp_frame.sv]
// How it works
// - idle waits for STX, command text, LF, then ETX.
// - valid complete command answered with one ACK byte.
// - invalid complete command answered with one NAK byte.
// - each reply block goes out as STX, data, CR, LF, ETX.
// - blocks repeat until data run out, then EOT and back to idle.
// - response timer starts once the closing ETX has left.
// - response timer stops on ACK from the host.
// - response timeout sends EOT and returns to idle.
// - response timeout is fixed at 15 seconds; the code sets it by RSP_TIMEOUT_TICKS, 15 seconds by default.
// - receive timer starts on the opening STX.
// - receive timer restarts on every received byte.
// - receive timer stops on the closing ETX.
// - receive timeout drops the partial command and returns to idle.
// - receive timeout is fixed at 15 seconds; the code sets it by RCV_TIMEOUT_TICKS, 15 seconds by default.
`timescale 1ns/1ps
`default_nettype none

module scfp_frame
    import scfp_pkg::*;
#(
    parameter int TICK_CYCLES = SCFP_TICK_CYCLES,
    parameter int RSP_TIMEOUT_TICKS = SCFP_RSP_TIMEOUT_TICKS,
    parameter int RCV_TIMEOUT_TICKS = SCFP_RCV_TIMEOUT_TICKS
) (
    input wire logic CLK,
    input wire logic RESETN,
    // byte stream from the serial receiver
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    // byte stream to the serial transmitter
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    // command text to the parser
    output logic [7:0] CMD_DATA,
    output logic CMD_VALID,
    output logic CMD_END,
    output logic CMD_ABORT,
    // parser verdict on a finished command
    input wire logic VERDICT_VALID,
    input wire logic VERDICT_OK,
    input wire logic VERDICT_QUERY,
    // reply data from the instrument
    input wire logic [7:0] RSP_DATA,
    input wire logic RSP_LAST,
    input wire logic RSP_VALID,
    output logic RSP_READY,
    input wire logic RSP_MORE,
    // status
    output logic LINK_IDLE,
    output logic RSP_TIMEOUT,
    output logic RCV_TIMEOUT
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        scfp_state_t st;
        logic [7:0] tx_data;
        logic tx_valid;
        logic [7:0] cmd_data;
        logic cmd_valid;
        logic cmd_end;
        logic cmd_abort;
        logic last_lf;
        logic reply_nak;
        logic query;
        logic idle;
        logic [SCFP_PRE_W-1:0] pre;
        logic [SCFP_TMR_W-1:0] rsp_cnt;
        logic rsp_run;
        logic [SCFP_TMR_W-1:0] rcv_cnt;
        logic rcv_run;
        logic rsp_to;
        logic rcv_to;
    } scfp_regs_t;

    localparam logic [SCFP_PRE_W-1:0] PRE_LAST = SCFP_PRE_W'(TICK_CYCLES - 1);
    localparam logic [SCFP_TMR_W-1:0] RSP_LAST_TICK = SCFP_TMR_W'(RSP_TIMEOUT_TICKS - 1);
    localparam logic [SCFP_TMR_W-1:0] RCV_LAST_TICK = SCFP_TMR_W'(RCV_TIMEOUT_TICKS - 1);

    scfp_regs_t r;
    scfp_regs_t next_r;

    logic [SCFP_FIFO_W-1:0] f_data;
    logic f_valid;
    logic f_ready;
    logic tick;
    logic tx_free;
    logic rsp_expire;
    logic rcv_expire;
    logic rx_stx;
    logic rx_etx;

    // ********************************************************
    // reply buffer
    // ********************************************************
    scfp_fifo #(
        .WIDTH(SCFP_FIFO_W),
        .DEPTH(SCFP_FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .resetn(RESETN),
        .in_data({RSP_LAST, RSP_DATA}),
        .in_valid(RSP_VALID),
        .in_ready(RSP_READY),
        .out_data(f_data),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );

    // ********************************************************
    // helpers
    // ********************************************************
    assign tick = r.pre == PRE_LAST;
    assign tx_free = !r.tx_valid || TX_READY;
    assign rsp_expire = r.rsp_run && tick && (r.rsp_cnt == RSP_LAST_TICK);
    assign rcv_expire = r.rcv_run && tick && (r.rcv_cnt == RCV_LAST_TICK);
    assign rx_stx = RX_VALID && (RX_DATA == SCFP_STX);
    assign rx_etx = RX_VALID && (RX_DATA == SCFP_ETX);
    assign f_ready = (r.st == SCFP_ST_TX_DATA) && tx_free;

    // where to go once a block is done or the reply was requested
    function automatic scfp_state_t scfp_next_block(input logic avail, input logic more);
        scfp_state_t s;
        if (avail) begin
            s = SCFP_ST_TX_STX;
        end else if (more) begin
            s = SCFP_ST_WAIT_BLOCK;
        end else begin
            s = SCFP_ST_TX_EOT;
        end
        return s;
    endfunction

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        next_r = r;
        next_r.cmd_valid = 1'b0;
        next_r.cmd_end = 1'b0;
        next_r.cmd_abort = 1'b0;
        next_r.rsp_to = 1'b0;
        next_r.rcv_to = 1'b0;
        if (TX_READY) begin
            next_r.tx_valid = 1'b0;
        end

        // prescaler and timer counting
        next_r.pre = tick ? '0 : r.pre + SCFP_PRE_W'(1);
        if (r.rsp_run && tick) begin
            next_r.rsp_cnt = r.rsp_cnt + SCFP_TMR_W'(1);
        end
        if (r.rcv_run && tick) begin
            next_r.rcv_cnt = r.rcv_cnt + SCFP_TMR_W'(1);
        end

        case (r.st)
            SCFP_ST_IDLE: begin
                if (rx_stx) begin
                    next_r.st = SCFP_ST_RX_BODY;
                    next_r.last_lf = 1'b0;
                    next_r.rcv_run = 1'b1;
                    next_r.rcv_cnt = '0;
                    next_r.pre = '0;
                end
            end

            SCFP_ST_RX_BODY: begin
                if (rcv_expire) begin
                    next_r.cmd_abort = 1'b1;
                    next_r.rcv_run = 1'b0;
                    next_r.rcv_to = 1'b1;
                    next_r.st = SCFP_ST_IDLE;
                end else if (RX_VALID) begin
                    next_r.rcv_cnt = '0;
                    next_r.pre = '0;
                    if (rx_stx) begin
                        // a fresh STX restarts the frame
                        next_r.cmd_abort = 1'b1;
                        next_r.last_lf = 1'b0;
                    end else if (rx_etx) begin
                        next_r.rcv_run = 1'b0;
                        if (r.last_lf) begin
                            next_r.cmd_end = 1'b1;
                            next_r.st = SCFP_ST_WAIT_VERDICT;
                        end else begin
                            // ETX without LF: malformed, refused
                            next_r.cmd_abort = 1'b1;
                            next_r.reply_nak = 1'b1;
                            next_r.query = 1'b0;
                            next_r.st = SCFP_ST_REPLY;
                        end
                    end else begin
                        next_r.cmd_data = RX_DATA;
                        next_r.cmd_valid = 1'b1;
                        next_r.last_lf = RX_DATA == SCFP_LF;
                    end
                end
            end

            SCFP_ST_WAIT_VERDICT: begin
                if (VERDICT_VALID) begin
                    next_r.reply_nak = !VERDICT_OK;
                    next_r.query = VERDICT_OK && VERDICT_QUERY;
                    next_r.st = SCFP_ST_REPLY;
                end
            end

            SCFP_ST_REPLY: begin
                if (tx_free) begin
                    next_r.tx_data = r.reply_nak ? SCFP_NAK : SCFP_ACK;
                    next_r.tx_valid = 1'b1;
                    next_r.st = r.query ? SCFP_ST_WAIT_EOT : SCFP_ST_IDLE;
                end
            end

            SCFP_ST_WAIT_EOT: begin
                if (RX_VALID && (RX_DATA == SCFP_EOT)) begin
                    next_r.st = scfp_next_block(f_valid, RSP_MORE);
                end else if (rx_stx) begin
                    // host gave up on the reply and sends a new command
                    next_r.st = SCFP_ST_RX_BODY;
                    next_r.last_lf = 1'b0;
                    next_r.rcv_run = 1'b1;
                    next_r.rcv_cnt = '0;
                    next_r.pre = '0;
                end
            end

            SCFP_ST_WAIT_BLOCK: begin
                if (f_valid) begin
                    next_r.st = SCFP_ST_TX_STX;
                end else if (!RSP_MORE) begin
                    next_r.st = SCFP_ST_TX_EOT;
                end
            end

            SCFP_ST_TX_STX: begin
                if (tx_free) begin
                    next_r.tx_data = SCFP_STX;
                    next_r.tx_valid = 1'b1;
                    next_r.st = SCFP_ST_TX_DATA;
                end
            end

            SCFP_ST_TX_DATA: begin
                if (tx_free && f_valid) begin
                    next_r.tx_data = f_data[SCFP_BYTE_W-1:0];
                    next_r.tx_valid = 1'b1;
                    if (f_data[SCFP_LAST_BIT]) begin
                        next_r.st = SCFP_ST_TX_CR;
                    end
                end
            end

            SCFP_ST_TX_CR: begin
                if (tx_free) begin
                    next_r.tx_data = SCFP_CR;
                    next_r.tx_valid = 1'b1;
                    next_r.st = SCFP_ST_TX_LF;
                end
            end

            SCFP_ST_TX_LF: begin
                if (tx_free) begin
                    next_r.tx_data = SCFP_LF;
                    next_r.tx_valid = 1'b1;
                    next_r.st = SCFP_ST_TX_ETX;
                end
            end

            SCFP_ST_TX_ETX: begin
                if (tx_free) begin
                    next_r.tx_data = SCFP_ETX;
                    next_r.tx_valid = 1'b1;
                    next_r.st = SCFP_ST_TX_DRAIN;
                end
            end

            SCFP_ST_TX_DRAIN: begin
                // ETX is held on TX_DATA; timer runs from its acceptance
                if (TX_READY) begin
                    next_r.rsp_run = 1'b1;
                    next_r.rsp_cnt = '0;
                    next_r.pre = '0;
                    next_r.st = SCFP_ST_WAIT_ACK;
                end
            end

            SCFP_ST_WAIT_ACK: begin
                if (rsp_expire) begin
                    next_r.rsp_run = 1'b0;
                    next_r.rsp_to = 1'b1;
                    next_r.st = SCFP_ST_TX_EOT;
                end else if (RX_VALID && (RX_DATA == SCFP_ACK)) begin
                    next_r.rsp_run = 1'b0;
                    next_r.st = scfp_next_block(f_valid, RSP_MORE);
                end
            end

            SCFP_ST_TX_EOT: begin
                if (tx_free) begin
                    next_r.tx_data = SCFP_EOT;
                    next_r.tx_valid = 1'b1;
                    next_r.st = SCFP_ST_IDLE;
                end
            end

            default: begin
                next_r.st = SCFP_ST_IDLE;
            end
        endcase

        next_r.idle = next_r.st == SCFP_ST_IDLE;
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            r <= '0;
            r.idle <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************
    assign TX_DATA = r.tx_data;
    assign TX_VALID = r.tx_valid;
    assign CMD_DATA = r.cmd_data;
    assign CMD_VALID = r.cmd_valid;
    assign CMD_END = r.cmd_end;
    assign CMD_ABORT = r.cmd_abort;
    assign LINK_IDLE = r.idle;
    assign RSP_TIMEOUT = r.rsp_to;
    assign RCV_TIMEOUT = r.rcv_to;

endmodule // scfp_frame

`default_nettype wire

// [dv/scfp_frame_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

module scfp_frame_assertions
    import scfp_pkg::*;
#(
    parameter int TICK_CYCLES = 4,
    parameter int RSP_TIMEOUT_TICKS = 5,
    parameter int RCV_TIMEOUT_TICKS = 5
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic CMD_END,
    input wire logic CMD_ABORT,
    input wire logic VERDICT_VALID,
    input wire logic VERDICT_OK,
    input wire logic VERDICT_QUERY,
    input wire logic LINK_IDLE,
    input wire logic RSP_TIMEOUT,
    input wire logic RCV_TIMEOUT
);
    // ****************************************
    // cycle counters behind the timer checks
    // ****************************************
    localparam int RSP_T = RSP_TIMEOUT_TICKS * TICK_CYCLES;
    localparam int RCV_T = RCV_TIMEOUT_TICKS * TICK_CYCLES;
    int rsp_cnt;
    int rcv_cnt;
    logic pend;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rsp_cnt <= 0;
            rcv_cnt <= 0;
            pend <= 1'h0;
        end else begin
            rsp_cnt <= (TX_VALID && TX_READY && TX_DATA == SCFP_ETX) ? 0 : rsp_cnt + 1;
            rcv_cnt <= RX_VALID ? 0 : rcv_cnt + 1;
            pend <= CMD_END || (pend && !VERDICT_VALID);
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_good;
        pend && VERDICT_VALID && VERDICT_OK;
    endsequence
    sequence s_bad;
        pend && VERDICT_VALID && !VERDICT_OK;
    endsequence
    sequence s_cr_sent;
        TX_VALID && TX_READY && TX_DATA == SCFP_CR;
    endsequence
    // verdict is taken, then the reply state loads the byte: two edges, more while the transmitter is busy
    a_ack_on_good: assert property (s_good |-> ##[2:5] (TX_VALID && TX_DATA == SCFP_ACK))
        else $error("no ACK after a good verdict");
    a_nak_on_bad: assert property (s_bad |-> ##[2:5] (TX_VALID && TX_DATA == SCFP_NAK))
        else $error("no NAK after a bad verdict");
    a_end_after_etx: assert property (CMD_END |-> $past(RX_VALID) && $past(RX_DATA) == SCFP_ETX)
        else $error("command end without a closing ETX");
    a_lf_follows_cr: assert property (s_cr_sent |=> TX_VALID && TX_DATA == SCFP_LF)
        else $error("CR not followed by LF");
    a_tx_held: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("transmit byte changed before acceptance");
    a_eot_on_rto: assert property (RSP_TIMEOUT |-> ##[0:2] (TX_VALID && TX_DATA == SCFP_EOT))
        else $error("no EOT after response timeout");
    a_rto_period: assert property (RSP_TIMEOUT |-> rsp_cnt inside {[RSP_T-2:RSP_T+3]})
        else $error("response timeout at wrong time");
    a_rcv_drop: assert property (RCV_TIMEOUT |-> CMD_ABORT ##[0:1] LINK_IDLE)
        else $error("receive timeout without abort and idle");
    a_rcv_period: assert property (RCV_TIMEOUT |-> rcv_cnt inside {[RCV_T-2:RCV_T+2]})
        else $error("receive timeout at wrong time");
    a_idle_after_cmd: assert property (s_good ##0 !VERDICT_QUERY |-> ##[1:3] LINK_IDLE)
        else $error("no return to idle after plain command");
endmodule // scfp_frame_assertions

bind scfp_frame scfp_frame_assertions #(.TICK_CYCLES(TICK_CYCLES), .RSP_TIMEOUT_TICKS(RSP_TIMEOUT_TICKS),
    .RCV_TIMEOUT_TICKS(RCV_TIMEOUT_TICKS)) u_scfp_frame_assertions (.CLK(CLK), .RESETN(RESETN),
    .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .CMD_END(CMD_END), .CMD_ABORT(CMD_ABORT), .VERDICT_VALID(VERDICT_VALID), .VERDICT_OK(VERDICT_OK),
    .VERDICT_QUERY(VERDICT_QUERY), .LINK_IDLE(LINK_IDLE), .RSP_TIMEOUT(RSP_TIMEOUT), .RCV_TIMEOUT(RCV_TIMEOUT));

`default_nettype wire

// [dv/scfp_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module scfp_host_model
    import scfp_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid
);
    // ****************************************
    // host side of the serial byte link
    // ****************************************
    logic stall = 1'h0;
    logic [7:0] got[$];
    int ph = 0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'h0;
        tx_ready = 1'h1;
    end
    // stalling host takes only one byte in three
    always @(negedge clk) begin
        ph <= (ph + 1) % 3;
        tx_ready <= !stall || ph == 0;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end
    // idle line shows the inverse of the last byte
    task automatic send(input logic [7:0] b);
        @(negedge clk);
        rx_data <= b;
        rx_valid <= 1'h1;
        @(negedge clk);
        rx_valid <= 1'h0;
        rx_data <= ~b;
    endtask
    task automatic request_reply;
        send(SCFP_EOT);
    endtask
    task automatic ack_block;
        send(SCFP_ACK);
    endtask
endmodule // scfp_host_model

`default_nettype wire

// [dv/scfp_frame_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module scfp_frame_tb
    import scfp_pkg::*;
();
    // ****************************************
    // bench, parser and instrument side
    // ****************************************
    localparam int TC = 4;
    localparam int TT = 5;
    logic CLK = 1'h0;
    logic RESETN = 1'h0;
    logic [7:0] RX_DATA, TX_DATA, CMD_DATA;
    logic RX_VALID, TX_VALID, TX_READY, CMD_VALID, CMD_END, CMD_ABORT, RSP_READY;
    logic LINK_IDLE, RSP_TIMEOUT, RCV_TIMEOUT;
    logic VERDICT_VALID = 1'h0, VERDICT_OK = 1'h0, VERDICT_QUERY = 1'h0;
    logic [7:0] RSP_DATA = 8'h00;
    logic RSP_LAST = 1'h0, RSP_VALID = 1'h0, RSP_MORE = 1'h0;
    int err_count = 0, checks_done = 0;
    int n_end = 0, n_abort = 0, n_rto = 0, n_rcvto = 0;
    logic [7:0] cq[$];

    scfp_frame #(.TICK_CYCLES(TC), .RSP_TIMEOUT_TICKS(TT), .RCV_TIMEOUT_TICKS(TT)) u_scfp_frame (
        .CLK(CLK), .RESETN(RESETN), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .TX_DATA(TX_DATA),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .CMD_DATA(CMD_DATA), .CMD_VALID(CMD_VALID),
        .CMD_END(CMD_END), .CMD_ABORT(CMD_ABORT), .VERDICT_VALID(VERDICT_VALID), .VERDICT_OK(VERDICT_OK),
        .VERDICT_QUERY(VERDICT_QUERY), .RSP_DATA(RSP_DATA), .RSP_LAST(RSP_LAST), .RSP_VALID(RSP_VALID),
        .RSP_READY(RSP_READY), .RSP_MORE(RSP_MORE), .LINK_IDLE(LINK_IDLE), .RSP_TIMEOUT(RSP_TIMEOUT),
        .RCV_TIMEOUT(RCV_TIMEOUT));
    scfp_host_model u_scfp_host_model (.clk(CLK), .tx_data(TX_DATA), .tx_valid(TX_VALID),
        .tx_ready(TX_READY), .rx_data(RX_DATA), .rx_valid(RX_VALID));

    always #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (CMD_VALID === 1'h1) begin
            cq.push_back(CMD_DATA);
        end
        n_end += int'(CMD_END === 1'h1);
        n_abort += int'(CMD_ABORT === 1'h1);
        n_rto += int'(RSP_TIMEOUT === 1'h1);
        n_rcvto += int'(RCV_TIMEOUT === 1'h1);
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ran_out;
        err_count++;
        $display("ERROR %0t wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic expect_bytes(input logic [7:0] exp[$]);
        int k;
        for (k = 0; k < 3000 && u_scfp_host_model.got.size() < exp.size(); k++) @(negedge CLK);
        if (u_scfp_host_model.got.size() < exp.size()) ran_out();
        foreach (exp[i]) check(u_scfp_host_model.got[i], exp[i]);
        u_scfp_host_model.got.delete();
    endtask
    task automatic cmd(input logic ok, input logic q);
        int k;
        int e;
        e = n_end;
        cq.delete();
        u_scfp_host_model.send(SCFP_STX);
        u_scfp_host_model.send(8'h41);
        u_scfp_host_model.send(SCFP_LF);
        u_scfp_host_model.send(SCFP_ETX);
        for (k = 0; k < 20 && n_end == e; k++) @(negedge CLK);
        if (n_end == e) ran_out();
        check(n_end, e + 1);
        check({cq[0], cq[1]}, {8'h41, SCFP_LF});
        VERDICT_VALID = 1'h1;
        VERDICT_OK = ok;
        VERDICT_QUERY = q;
        @(negedge CLK);
        VERDICT_VALID = 1'h0;
    endtask

    task automatic t_plain;
        cmd(1'h1, 1'h0);
        expect_bytes('{SCFP_ACK});
        repeat (2 * TC * TT) @(negedge CLK);
        check(LINK_IDLE, 1'h1);
        check(u_scfp_host_model.got.size(), 0);
        check(n_rcvto, 0);
    endtask
    task automatic t_bad;
        int e;
        cmd(1'h0, 1'h0);
        expect_bytes('{SCFP_NAK});
        e = n_end;
        u_scfp_host_model.send(SCFP_STX);
        u_scfp_host_model.send(8'h42);
        u_scfp_host_model.send(SCFP_ETX);
        expect_bytes('{SCFP_NAK});
        check(n_end, e);
    endtask
    task automatic t_fill_query;
        int n;
        logic [7:0] exp[$];
        n = 0;
        RSP_MORE = 1'h1;
        RSP_VALID = 1'h1;
        while (RSP_READY === 1'h1 && n < 40) begin
            RSP_DATA = 8'h20 + 8'(n);
            @(negedge CLK);
            n++;
        end
        RSP_VALID = 1'h0;
        check(n >= 32 && n <= 33, 1'h1);
        u_scfp_host_model.stall = 1'h1;
        cmd(1'h1, 1'h1);
        expect_bytes('{SCFP_ACK});
        check(LINK_IDLE, 1'h0);
        u_scfp_host_model.request_reply();
        exp = '{SCFP_STX};
        for (int i = 0; i < n; i++) exp.push_back(8'h20 + 8'(i));
        expect_bytes(exp);
        RSP_DATA = 8'h7E;
        RSP_LAST = 1'h1;
        RSP_VALID = 1'h1;
        @(negedge CLK);
        RSP_VALID = 1'h0;
        RSP_LAST = 1'h0;
        RSP_MORE = 1'h0;
        expect_bytes('{8'h7E, SCFP_CR, SCFP_LF, SCFP_ETX});
        u_scfp_host_model.send(SCFP_NAK);
        u_scfp_host_model.ack_block();
        expect_bytes('{SCFP_EOT});
        repeat (2 * TC * TT) @(negedge CLK);
        check(n_rto, 0);
        check(LINK_IDLE, 1'h1);
        u_scfp_host_model.stall = 1'h0;
    endtask
    task automatic t_rsp_timeout;
        int k;
        int e;
        e = n_rto;
        RSP_DATA = 8'h58;
        RSP_LAST = 1'h1;
        RSP_VALID = 1'h1;
        @(negedge CLK);
        RSP_VALID = 1'h0;
        RSP_LAST = 1'h0;
        cmd(1'h1, 1'h1);
        expect_bytes('{SCFP_ACK});
        u_scfp_host_model.request_reply();
        expect_bytes('{SCFP_STX, 8'h58, SCFP_CR, SCFP_LF, SCFP_ETX});
        for (k = 0; k < 200 && n_rto == e; k++) @(negedge CLK);
        if (n_rto == e) ran_out();
        check(k >= TC * TT - 3 && k <= TC * TT + 3, 1'h1);
        expect_bytes('{SCFP_EOT});
        check(LINK_IDLE, 1'h1);
    endtask
    task automatic t_rcv_timeout;
        int k;
        int a;
        int b;
        a = n_abort;
        b = n_rcvto;
        u_scfp_host_model.send(SCFP_STX);
        repeat (3) begin
            u_scfp_host_model.send(8'h43);
            repeat (TC * TT - 6) @(negedge CLK);
        end
        check(n_rcvto, b);
        for (k = 0; k < 200 && n_rcvto == b; k++) @(negedge CLK);
        if (n_rcvto == b) ran_out();
        check(k <= 10, 1'h1);
        check(n_abort, a + 1);
        check(LINK_IDLE, 1'h1);
        cmd(1'h1, 1'h0);
        expect_bytes('{SCFP_ACK});
    endtask

    initial begin
        repeat (5) @(negedge CLK);
        check({LINK_IDLE, TX_VALID, RSP_READY, RSP_TIMEOUT, RCV_TIMEOUT}, 5'h14);
        repeat (5) @(negedge CLK);
        RESETN = 1'h1;
        t_plain();
        t_bad();
        t_fill_query();
        t_rsp_timeout();
        t_rcv_timeout();
        tally_and_finish();
    end
endmodule // scfp_frame_tb

`default_nettype wire
